// file: hdl/dim_fifo.v
// small synchronous fifo with registered read data
// assumes one clock; the head word is valid whenever outValid is high
`timescale 1ns/10ps
module dim_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // fill side
    input wire inValid,
    input wire [WIDTH-1:0] inData,
    output wire inReady,
    // drain side
    output wire outValid,
    output wire [WIDTH-1:0] outData,
    input wire outReady,
    // fill level
    output wire [AW:0] level
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wrPtr_r;
reg [AW-1:0] rdPtr_r;
reg [AW:0] count_r;
reg ready_r;
reg valid_r;
reg [WIDTH-1:0] head_r;
wire push;
wire pop;
wire [AW-1:0] rdPtr_nxt;
wire [AW:0] count_nxt;

assign push = inValid && ready_r;
assign pop = outReady && valid_r;
assign rdPtr_nxt = pop ? rdPtr_r + {{(AW-1){1'b0}}, 1'b1} : rdPtr_r;
assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
assign inReady = ready_r;
assign outValid = valid_r;
assign outData = head_r;
assign level = count_r;

// storage array; no reset so it maps to memory
always @(posedge clk) begin
    if (push) begin
        mem[wrPtr_r] <= inData;
    end
end

// pointers, count and flags from registers so both sides see clean levels
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        wrPtr_r <= {AW{1'b0}};
        rdPtr_r <= {AW{1'b0}};
        count_r <= {(AW+1){1'b0}};
        ready_r <= 1'b1;
        valid_r <= 1'b0;
        head_r <= {WIDTH{1'b0}};
    end else begin
        if (push) begin
            wrPtr_r <= wrPtr_r + {{(AW-1){1'b0}}, 1'b1};
        end
        rdPtr_r <= rdPtr_nxt;
        count_r <= count_nxt;
        ready_r <= (count_nxt != DEPTH);
        valid_r <= (count_nxt != {(AW+1){1'b0}});
        // bypass a word written to the head slot in this very cycle
        if (push && (wrPtr_r == rdPtr_nxt)) begin
            head_r <= inData;
        end else begin
            head_r <= mem[rdPtr_nxt];
        end
    end
end

endmodule

// file: hdl/dim_map.vh
// constants for the dual interpolating quadrature modulator
// assumes 16-bit two's complement samples and an 8-bit register port
`ifndef DIM_MAP_VH
`define DIM_MAP_VH

// register offsets
`define DIM_REG_MODE 8'h01
`define DIM_REG_STAT 8'h03

// mode register fields and reset value
`define DIM_MODE_RST 8'h00
`define DIM_MIXREAL_BIT 2
`define DIM_NEGROT_BIT 3
`define DIM_MODSEL_LSB 4
`define DIM_INTERP_LSB 6

// status register fields
`define DIM_STAT_UNDER_BIT 4
`define DIM_STAT_SAT_BIT 5
`define DIM_STAT_RUN_BIT 6

// modulation select codes
`define DIM_MOD_OFF 2'h0
`define DIM_MOD_HALF 2'h1
`define DIM_MOD_QUART 2'h2
`define DIM_MOD_EIGHTH 2'h3

// half-band odd-phase coefficients sum to 2^14; each serves two taps, so unity is 2^15
`define DIM_HB_C1 16'h4DBC
`define DIM_HB_C3 16'hEC78
`define DIM_HB_C5 16'h0898
`define DIM_HB_C7 16'hFC4A
`define DIM_HB_C9 16'h017C
`define DIM_HB_C11 16'hFF6E
`define DIM_HB_SHIFT 15

// carrier amplitudes in 17-bit Q15
`define DIM_CAR_ONE 17'h08000
`define DIM_CAR_MONE 17'h18000
`define DIM_CAR_R2 17'h05A82
`define DIM_CAR_MR2 17'h1A57E
`define DIM_CAR_ZERO 17'h00000
`define DIM_CAR_SHIFT 15

// fifo shape
`define DIM_FIFO_DEPTH 8
`define DIM_FIFO_AW 3

`endif

// file: hdl/dim_modulator.v
// dual interpolating quadrature modulator: fifo, 3 half-band stages per path,
// carrier generator and real or complex mixer ahead of the two dac outputs.
// assumes clk is the dac output rate fs; samples arrive on a valid/ready port.
// Summary of operation
// - I and Q each own an independent chain of three cascaded half-band stages, up to 8x.
// - the half-band coefficients are chosen for image attenuation above 75 dB at fs.
// - a modulation-select code of 00 bypasses both mixers, leaving a plain 1x-8x interpolator.
// - a nonzero modulation-select code runs the mixers at fs/2, fs/4 or fs/8.
// - with the mix-type bit at 1 each path is mixed alone with no cross terms.
// - with the mix-type bit at 0 the two paths form one complex multiply by the carrier.
// - a sign bit picks positive or negative rotation in complex mode.
// - the carrier is fs divided by 2, 4 or 8 and nothing else.
// - the complex mixer uses cosine and sine terms and reverses rotation by negating sine.
// - stages run from synchronous rate strobes at 1x, 2x, 4x and 8x the input rate; the mixer runs every fs cycle.
`timescale 1ns/10ps
`include "dim_map.vh"
module dim_modulator (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // baseband sample input
    input wire inValid,
    input wire [15:0] inI,
    input wire [15:0] inQ,
    output wire inReady,
    // dac codes at fs
    output reg [15:0] dacI_r,
    output reg [15:0] dacQ_r,
    output reg dacValid_r,
    // register port
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdData_r
);

// saturate a wide signed value to 16 bits
function [15:0] sat16;
    input signed [35:0] v;
    begin
        if (v > 36'sd32767) begin
            sat16 = 16'h7FFF;
        end else if (v < -36'sd32768) begin
            sat16 = 16'h8000;
        end else begin
            sat16 = v[15:0];
        end
    end
endfunction

// low-bit mask used to pick every 2^k-th cycle
function [2:0] lowMask;
    input [1:0] k;
    begin
        case (k)
            2'h0: lowMask = 3'h0;
            2'h1: lowMask = 3'h1;
            2'h2: lowMask = 3'h3;
            default: lowMask = 3'h7;
        endcase
    end
endfunction

reg [7:0] mode_r;
reg under_r;
reg sat_r;
reg run_r;
reg [2:0] ph_r;
reg [15:0] smpI_r;
reg [15:0] smpQ_r;
wire [1:0] nStages;
wire [1:0] modSel;
wire mixReal;
wire negRot;
wire fifoValid;
wire [31:0] fifoData;
wire [3:0] fifoLevel;
wire popStb;
wire [5:0] stSat;
wire [95:0] stOut;
wire [2:0] outStb;
wire [2:0] inStb;
wire statRd;

assign nStages = mode_r[`DIM_INTERP_LSB+1:`DIM_INTERP_LSB];
assign modSel = mode_r[`DIM_MODSEL_LSB+1:`DIM_MODSEL_LSB];
assign mixReal = mode_r[`DIM_MIXREAL_BIT];
assign negRot = mode_r[`DIM_NEGROT_BIT];
assign statRd = regRd && (regAddr == `DIM_REG_STAT);

// input fifo absorbs bursts; inReady back-pressures the source when full
dim_fifo #(
    .WIDTH(32),
    .DEPTH(`DIM_FIFO_DEPTH),
    .AW(`DIM_FIFO_AW)
) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .inValid(inValid),
    .inData({inI, inQ}),
    .inReady(inReady),
    .outValid(fifoValid),
    .outData(fifoData),
    .outReady(popStb),
    .level(fifoLevel)
);

// rate phase
// free-running phase at fs; its low bits give every lower synchronous rate
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        ph_r <= 3'h0;
    end else begin
        ph_r <= ph_r + 3'h1;
    end
end

// rate strobes
// the input rate is fs over 2^nStages; stage s doubles it, unused stages get no output strobe
assign popStb = ((ph_r & lowMask(nStages)) == 3'h0);

genvar gs;
generate
    for (gs = 0; gs < 3; gs = gs + 1) begin : g_stb
        localparam [1:0] SIDX = gs;
        assign outStb[gs] = (SIDX < nStages) && ((ph_r & lowMask(nStages - SIDX - 2'h1)) == 3'h0);
        if (gs == 0) begin : g_first
            assign inStb[gs] = (nStages != 2'h0) && popStb;
        end else begin : g_next
            assign inStb[gs] = outStb[gs-1];
        end
    end
endgenerate

// sample hold at the input rate; an empty fifo feeds zeros rather than stalling fs
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        smpI_r <= 16'h0000;
        smpQ_r <= 16'h0000;
    end else if (popStb) begin
        smpI_r <= fifoValid ? fifoData[31:16] : 16'h0000;
        smpQ_r <= fifoValid ? fifoData[15:0] : 16'h0000;
    end
end

// independent chains
// one half-band stage per path and per position; index g = path*3 + stage
genvar g;
generate
    for (g = 0; g < 6; g = g + 1) begin : g_hb
        localparam S = g % 3;
        reg [15:0] tap [0:11];
        reg [15:0] out_r;
        reg sat_r;
        wire [15:0] din;
        reg signed [35:0] acc;
        integer k;
        if (S == 0) begin : g_src0
            assign din = (g < 3) ? smpI_r : smpQ_r;
        end else begin : g_srcn
            assign din = stOut[(g-1)*16 +: 16];
        end
        // half-band taps
        // odd phase: symmetric pairs around the centre, twelve products weigh 2^15
        always @* begin
            acc = 36'sd0;
            acc = $signed(`DIM_HB_C1) * ($signed(tap[5]) + $signed(tap[6]))
                + $signed(`DIM_HB_C3) * ($signed(tap[4]) + $signed(tap[7]))
                + $signed(`DIM_HB_C5) * ($signed(tap[3]) + $signed(tap[8]))
                + $signed(`DIM_HB_C7) * ($signed(tap[2]) + $signed(tap[9]))
                + $signed(`DIM_HB_C9) * ($signed(tap[1]) + $signed(tap[10]))
                + $signed(`DIM_HB_C11) * ($signed(tap[0]) + $signed(tap[11]));
            acc = acc >>> `DIM_HB_SHIFT;
        end
        // rate doubling
        // even phase repeats the centre sample, odd phase is the filtered midpoint
        always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                for (k = 0; k < 12; k = k + 1) begin
                    tap[k] <= 16'h0000;
                end
                out_r <= 16'h0000;
                sat_r <= 1'b0;
            end else begin
                sat_r <= 1'b0;
                if (inStb[S]) begin
                    tap[0] <= din;
                    for (k = 1; k < 12; k = k + 1) begin
                        tap[k] <= tap[k-1];
                    end
                    out_r <= tap[5];
                end else if (outStb[S]) begin
                    out_r <= sat16(acc);
                    sat_r <= (acc > 36'sd32767) || (acc < -36'sd32768);
                end
            end
        end
        assign stOut[g*16 +: 16] = out_r;
        assign stSat[g] = sat_r;
    end
endgenerate

// bypass of upper stages
// the chain output is taken after the last active stage
reg [15:0] chainI;
reg [15:0] chainQ;
always @* begin
    case (nStages)
        2'h0: begin
            chainI = smpI_r;
            chainQ = smpQ_r;
        end
        2'h1: begin
            chainI = stOut[15:0];
            chainQ = stOut[63:48];
        end
        2'h2: begin
            chainI = stOut[31:16];
            chainQ = stOut[79:64];
        end
        default: begin
            chainI = stOut[47:32];
            chainQ = stOut[95:80];
        end
    endcase
end

// carrier generation
// trivial 0/+-1 sequences for fs/2 and fs/4, an eight-entry table for fs/8
reg signed [16:0] cosV;
reg signed [16:0] sinV;
always @* begin
    cosV = `DIM_CAR_ONE;
    sinV = `DIM_CAR_ZERO;
    case (modSel)
        `DIM_MOD_HALF: begin
            cosV = ph_r[0] ? `DIM_CAR_MONE : `DIM_CAR_ONE;
            sinV = `DIM_CAR_ZERO;
        end
        `DIM_MOD_QUART: begin
            case (ph_r[1:0])
                2'h0: begin
                    cosV = `DIM_CAR_ONE;
                    sinV = `DIM_CAR_ZERO;
                end
                2'h1: begin
                    cosV = `DIM_CAR_ZERO;
                    sinV = `DIM_CAR_ONE;
                end
                2'h2: begin
                    cosV = `DIM_CAR_MONE;
                    sinV = `DIM_CAR_ZERO;
                end
                default: begin
                    cosV = `DIM_CAR_ZERO;
                    sinV = `DIM_CAR_MONE;
                end
            endcase
        end
        `DIM_MOD_EIGHTH: begin
            case (ph_r)
                3'h0: begin
                    cosV = `DIM_CAR_ONE;
                    sinV = `DIM_CAR_ZERO;
                end
                3'h1: begin
                    cosV = `DIM_CAR_R2;
                    sinV = `DIM_CAR_R2;
                end
                3'h2: begin
                    cosV = `DIM_CAR_ZERO;
                    sinV = `DIM_CAR_ONE;
                end
                3'h3: begin
                    cosV = `DIM_CAR_MR2;
                    sinV = `DIM_CAR_R2;
                end
                3'h4: begin
                    cosV = `DIM_CAR_MONE;
                    sinV = `DIM_CAR_ZERO;
                end
                3'h5: begin
                    cosV = `DIM_CAR_MR2;
                    sinV = `DIM_CAR_MR2;
                end
                3'h6: begin
                    cosV = `DIM_CAR_ZERO;
                    sinV = `DIM_CAR_MONE;
                end
                default: begin
                    cosV = `DIM_CAR_R2;
                    sinV = `DIM_CAR_MR2;
                end
            endcase
        end
        default: begin
            cosV = `DIM_CAR_ONE;
            sinV = `DIM_CAR_ZERO;
        end
    endcase
end

// mixer; full-scale inputs at 45 degrees can exceed range, so the result saturates
reg signed [16:0] sinS;
reg signed [35:0] mixI;
reg signed [35:0] mixQ;
always @* begin
    sinS = negRot ? -sinV : sinV;
    mixI = {{20{chainI[15]}}, chainI};
    mixQ = {{20{chainQ[15]}}, chainQ};
    if (modSel != `DIM_MOD_OFF) begin
        if (mixReal) begin
            mixI = ($signed(chainI) * cosV) >>> `DIM_CAR_SHIFT;
            mixQ = ($signed(chainQ) * cosV) >>> `DIM_CAR_SHIFT;
        end else begin
            mixI = ($signed(chainI) * cosV - $signed(chainQ) * sinS) >>> `DIM_CAR_SHIFT;
            mixQ = ($signed(chainI) * sinS + $signed(chainQ) * cosV) >>> `DIM_CAR_SHIFT;
        end
    end
end

// mixer at fs
// dac codes register every fs cycle; valid rises once the first sample was taken
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        dacI_r <= 16'h0000;
        dacQ_r <= 16'h0000;
        dacValid_r <= 1'b0;
    end else begin
        dacI_r <= sat16(mixI);
        dacQ_r <= sat16(mixQ);
        dacValid_r <= run_r;
    end
end

// mode register and sticky status; an event in the clearing read cycle survives
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        mode_r <= `DIM_MODE_RST;
        under_r <= 1'b0;
        sat_r <= 1'b0;
        run_r <= 1'b0;
    end else begin
        if (regWr && (regAddr == `DIM_REG_MODE)) begin
            mode_r <= regWrData;
        end
        if (popStb && fifoValid) begin
            run_r <= 1'b1;
        end
        under_r <= (popStb && !fifoValid && run_r) || (under_r && !statRd);
        sat_r <= (|stSat) || (modSel != `DIM_MOD_OFF &&
            (mixI > 36'sd32767 || mixI < -36'sd32768 ||
             mixQ > 36'sd32767 || mixQ < -36'sd32768)) || (sat_r && !statRd);
    end
end

// read data one cycle after the strobe, zero elsewhere and for unmapped offsets
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        regRdData_r <= 8'h00;
    end else if (regRd && (regAddr == `DIM_REG_MODE)) begin
        regRdData_r <= mode_r;
    end else if (statRd) begin
        regRdData_r <= {1'b0, run_r, sat_r, under_r, fifoLevel};
    end else begin
        regRdData_r <= 8'h00;
    end
end

endmodule

// file: verif/dim_modulator_assertions.sv
// checker on the modulator top: register port, sample port, dac valid
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/10ps
module dim_modulator_assertions (
    // clock and reset
    input logic clk,
    input logic rst_n,
    // sample port
    input logic inValid,
    input logic [15:0] inI,
    input logic [15:0] inQ,
    input logic inReady,
    // dac side
    input logic [15:0] dacI_r,
    input logic [15:0] dacQ_r,
    input logic dacValid_r,
    // register port
    input logic [7:0] regAddr,
    input logic [7:0] regWrData,
    input logic regWr,
    input logic regRd,
    input logic [7:0] regRdData_r
);
    logic [7:0] modeShadow_r;
    logic gotWord_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // shadow of the mode register and a first-word flag
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            modeShadow_r <= 8'h00;
            gotWord_r <= 1'b0;
        end else begin
            if (regWr && regAddr == 8'h01) modeShadow_r <= regWrData;
            if (inValid && inReady) gotWord_r <= 1'b1;
        end
    end

    rd_idle_a: assert property (!regRd |=> regRdData_r == 8'h00)
        else $error("read data left standing");
    mode_rb_a: assert property (regRd && regAddr == 8'h01 |=> regRdData_r == modeShadow_r)
        else $error("mode readback differs");
    unmap_rd_a: assert property (regRd && regAddr != 8'h01 && regAddr != 8'h03 |=>
        regRdData_r == 8'h00) else $error("unmapped read not zero");
    stat_top_a: assert property (regRd && regAddr == 8'h03 |=>
        !regRdData_r[7] && regRdData_r[3:0] <= 4'h8) else $error("status out of range");
    valid_hold_a: assert property (dacValid_r |=> dacValid_r)
        else $error("dac valid dropped");
    valid_start_a: assert property (!gotWord_r |-> !dacValid_r)
        else $error("dac valid before any sample");
    dac_quiet_a: assert property (!dacValid_r |-> dacI_r == 16'h0000 && dacQ_r == 16'h0000)
        else $error("dac code before valid");
    ready_idle_a: assert property (inReady && !inValid |=> inReady)
        else $error("fifo filled without writes");

    eighth_c: cover property (regWr && regAddr == 8'h01 && regWrData == 8'h78);
    full_c: cover property (inValid && !inReady);
    under_c: cover property (regRd && regAddr == 8'h03 ##1 regRdData_r[4]);
endmodule

bind dim_modulator dim_modulator_assertions chk (.clk(clk), .rst_n(rst_n),
    .inValid(inValid), .inI(inI), .inQ(inQ), .inReady(inReady), .dacI_r(dacI_r),
    .dacQ_r(dacQ_r), .dacValid_r(dacValid_r), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData_r(regRdData_r));

// file: verif/dim_modulator_bench.sv
// bench for the dual interpolating quadrature modulator
// assumes dim_src feeds the sample port; dc input makes carrier checks phase-free
`timescale 1ns/10ps
module dim_modulator_bench;
    localparam logic [15:0] X = 16'h1000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic srcRun = 1'b0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic sawFull = 1'b0;
    logic [15:0] srcQ = 16'hF000;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic inValid, inReady, dacValid_r;
    logic [15:0] inI, inQ, dacI_r, dacQ_r;
    logic [7:0] regRdData_r, d;
    int taken, t0, cyc = 0, errors = 0, numChecks = 0;

    always #4 clk = ~clk;

    dim_src src (.clk(clk), .rst_n(rst_n), .run(srcRun), .smpI(X), .smpQ(srcQ),
        .inReady(inReady), .inValid(inValid), .inI(inI), .inQ(inQ), .taken(taken));
    dim_modulator DUT (.clk(clk), .rst_n(rst_n), .inValid(inValid), .inI(inI), .inQ(inQ),
        .inReady(inReady), .dacI_r(dacI_r), .dacQ_r(dacQ_r), .dacValid_r(dacValid_r),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData_r(regRdData_r));

    // hang guard; also notes a full fifo refusing words
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (!inReady) sawFull <= 1'b1;
        if (cyc == 20000) begin
            errors++;
            completeRun();
        end
    end

    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        numChecks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // rounding of the scaled carriers may move a code by one or two
    function automatic logic [15:0] fit(input logic [15:0] s, input logic [15:0] e);
        logic signed [16:0] dif;
        dif = $signed({s[15], s}) - $signed({e[15], e});
        if (dif <= 2 && dif >= -2) begin
            return e;
        end
        return s;
    endfunction

    task wr(input logic [7:0] a, input logic [7:0] v);
        regAddr <= a;
        regWrData <= v;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask

    task rd(input logic [7:0] a);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        d = regRdData_r;
        @(posedge clk);
    endtask

    // mixing at 2x with dc input; Q carries X in real mode, 0 in complex mode
    task mixChk(input logic [7:0] mode, input int p);
        logic signed [15:0] a[8];
        logic signed [15:0] b[8];
        logic [15:0] e;
        int hit;
        hit = 0;
        wr(8'h01, mode);
        srcQ <= mode[2] ? X : 16'h0000;
        repeat (200) @(posedge clk);
        for (int k = 0; k < 8; k++) begin
            #1;
            a[k] = dacI_r;
            b[k] = dacQ_r;
            hit += int'(a[k] == X);
            @(posedge clk);
        end
        for (int k = 0; k < 2; k++) begin
            chk("half period", fit(a[k + p / 2], -a[k]), -a[k]);
            if (mode[2]) begin
                chk("real q", fit(b[k], a[k]), a[k]);
            end else begin
                e = (p == 2) ? 16'h0000 : (mode[3] ? b[k] : -b[k]);
                chk("rotation", fit(p == 2 ? b[k] : a[k + p / 4], e), e);
            end
        end
        chk("carrier peak", {15'h0, hit != 0}, 16'h0001);
        $display("mix %h done", mode);
    endtask

    task completeRun();
        $display("checks %0d mismatches %0d", numChecks, errors);
        if (errors == 0 && numChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(8'h01);
        chk("mode reset", {8'h00, d}, 16'h0000);
        rd(8'h03);
        chk("status reset", {8'h00, d}, 16'h0000);
        wr(8'h01, 8'h5A);
        rd(8'h01);
        chk("mode readback", {8'h00, d}, 16'h005A);
        wr(8'h07, 8'hFF);
        rd(8'h07);
        chk("unmapped", {8'h00, d}, 16'h0000);
        $display("registers done");
        // each factor: dc passes at unity and input drains at fs over 2^n
        srcRun <= 1'b1;
        for (int n = 0; n < 4; n++) begin
            wr(8'h01, 8'(n << 6));
            repeat (500) @(posedge clk);
            t0 = taken;
            repeat (64) @(posedge clk);
            chk("input rate", 16'(taken - t0), 16'(64 >> n));
            #1;
            chk("dac i", fit(dacI_r, X), X);
            chk("dac q", fit(dacQ_r, 16'hF000), 16'hF000);
            @(posedge clk);
        end
        $display("interpolation done");
        mixChk(8'h54, 2);
        mixChk(8'h64, 4);
        mixChk(8'h74, 8);
        mixChk(8'h50, 2);
        mixChk(8'h60, 4);
        mixChk(8'h68, 4);
        mixChk(8'h70, 8);
        mixChk(8'h78, 8);
        // starve the fifo: zeros go out, valid stays, underrun is flagged
        wr(8'h01, 8'h00);
        srcRun <= 1'b0;
        repeat (300) @(posedge clk);
        #1;
        chk("idle dac", dacI_r, 16'h0000);
        chk("valid held", {15'h0, dacValid_r}, 16'h0001);
        @(posedge clk);
        rd(8'h03);
        chk("underrun", {8'h00, d & 8'h1F}, 16'h0010);
        chk("fifo full", {15'h0, sawFull}, 16'h0001);
        $display("underrun done");
        completeRun();
    end
endmodule

// file: verif/dim_src.sv
// sample source standing in for the input data port logic
// assumes the valid/ready port: a refused word is held until taken
`timescale 1ns/10ps
module dim_src (
    // clock and reset
    input logic clk,
    input logic rst_n,
    // bench control
    input logic run,
    input logic [15:0] smpI,
    input logic [15:0] smpQ,
    // sample port
    input logic inReady,
    output logic inValid,
    output logic [15:0] inI,
    output logic [15:0] inQ,
    output int taken
);
    // offer a word each cycle; idle lines toggle so sampling without valid shows
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            inValid <= 1'b0;
            inI <= 16'h0000;
            inQ <= 16'h0000;
            taken <= 0;
        end else begin
            if (inValid && inReady) begin
                taken <= taken + 1;
            end
            if (!inValid || inReady) begin
                inValid <= run;
                inI <= run ? smpI : ~inI;
                inQ <= run ? smpQ : ~inQ;
            end
        end
    end
endmodule
